//--- hw/msd_defs.vh
/*
 * Constants shared by the memory space decoder: the two control registers,
 * their fields and reset values, the address map and the bus phase timing.
 * Assumes it is included by bare name from every design file that needs it.
 */
`ifndef MSD_DEFS_VH
`define MSD_DEFS_VH

// ----------------------------------------------------------------
// Register locations in the special function register space
// ----------------------------------------------------------------
`define MSD_SFR_CLK_STRETCH 8'h8e
`define MSD_SFR_PWR_MGMT 8'hc4
`define MSD_SFR_BASE 8'h80

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define MSD_STRETCH_LSB 0
`define MSD_STRETCH_MSB 2
`define MSD_XRAM_EN_BIT 0
`define MSD_CLK_STRETCH_RST 8'h01
`define MSD_PWR_MGMT_RST 8'h00
`define MSD_PWR_MGMT_UNUSED 8'hfe
`define MSD_UNIMPL_READ 8'hff

// ----------------------------------------------------------------
// Address map
// ----------------------------------------------------------------
`define MSD_XRAM_LAST 16'h03ff
`define MSD_XRAM_AW 10
`define MSD_FLASH_TOP 16'h8000

// ----------------------------------------------------------------
// Timing: four clocks per machine cycle
// ----------------------------------------------------------------
`define MSD_CLK_PER_MC 3'h4
`define MSD_PHASE_LAST 2'h3
`define MSD_XRAM_MC 4'h2
`define MSD_EXTERNAL_DATA_MOVE_BASE_MC 4'h2
`define MSD_FLASH_MC 4'h1
// Address machine cycle plus one strobe machine cycle
`define MSD_FETCH_EXT_MC 4'h2

`endif

//--- hw/msd_xram.v
/*
 * On-chip data-move SRAM, one byte wide, synchronous write and read.
 * Assumes the caller gives at most one access per cycle and qualifies it.
 */
`include "msd_defs.vh"

module msd_xram #(
	parameter AW = `MSD_XRAM_AW
) (
	input wire clock, // System clock
	input wire ce, // Clock enable
	input wire en, // Access enable
	input wire we, // Write when high
	input wire [AW-1:0] addr, // Byte address
	input wire [7:0] wdata, // Write data
	output reg [7:0] rdata // Read data, one cycle after the request
);
	reg [7:0] mem [0:(1<<AW)-1];

	always @(posedge clock)
	begin
		if (ce && en)
		begin
			if (we)
				mem[addr] <= wdata;
			rdata <= mem[addr];
		end
	end
endmodule

//--- hw/msd_decoder.v
/*
 * Memory space decoder for an 8-bit core: routes fetches, code-table reads
 * and external data moves between internal flash, on-chip SRAM and the
 * multiplexed bus on ports 0 and 2; holds the stretch and SRAM-enable
 * registers and answers special function register reads.
 * Assumes one synchronous clock, a core that holds a request until done is
 * seen, and ports 0 and 2 resolved from the enables by the pad ring.
 */
`include "msd_defs.vh"

module msd_decoder #(
	parameter XRAM_AW = `MSD_XRAM_AW
) (
	input wire clock, // System clock, 100 MHz
	input wire rst, // Synchronous reset, active high
	input wire ce, // Clock enable, freezes all state when low
	input wire ext_access_pin, // External-access pin level
	input wire req, // Core request, held until done
	input wire [1:0] req_kind, // 0 fetch, 1 code read, 2 data read, 3 data write
	input wire [15:0] req_addr, // PC, code or data address
	input wire [7:0] req_wdata, // Data-move write data
	input wire sfr_rd, // Direct register read strobe
	input wire sfr_wr, // Direct register write strobe
	input wire sfr_bit, // Bit-addressed access
	input wire [7:0] sfr_addr, // Direct address
	input wire [2:0] sfr_bitsel, // Bit position for bit access
	input wire [7:0] sfr_wdata, // Register write data
	input wire [7:0] p0_latch, // Port 0 latch for plain I/O use
	input wire [7:0] p2_latch, // Port 2 latch for plain I/O use
	input wire [7:0] p0_in, // Port 0 pad input
	output reg done, // Request finished, one-cycle pulse
	output reg [7:0] rdata, // Read data, valid with done
	output reg from_flash, // Fetch or code read served by internal flash
	output reg [7:0] sfr_rdata, // Register read data
	output reg sfr_hit, // Read address is a block register
	output reg sfr_bit_err, // Bit access to non-bit-addressable location
	output reg [7:0] p0_out, // Port 0 output value
	output reg [7:0] p0_oe, // Port 0 output enables
	output reg [7:0] p2_out, // Port 2 output value
	output reg p2_strong, // Port 2 strong drive
	output reg addr_latch_en, // Address latch strobe
	output reg prog_rd_n, // External program read strobe
	output reg data_rd_n, // External data read strobe
	output reg data_wr_n, // External data write strobe
	output reg onchip_xram_enable // Current SRAM enable bit
);
	localparam ST_IDLE = 3'd0;
	localparam ST_FLASH = 3'd1;
	localparam ST_XRAM = 3'd2;
	localparam ST_ADDR = 3'd3;
	localparam ST_STROBE = 3'd4;
	localparam ST_END = 3'd5;

	localparam K_FETCH = 2'd0;
	localparam K_CODE = 2'd1;
	localparam K_DRD = 2'd2;
	localparam K_DWR = 2'd3;

	reg [7:0] clk_stretch_q;
	reg [7:0] pwr_mgmt_q;
	reg [2:0] state_q;
	reg [1:0] phase_q;
	reg [3:0] mc_q;
	reg [3:0] mc_end_q;
	reg [1:0] kind_q;
	reg [15:0] addr_q;
	reg [7:0] wdata_q;
	reg xram_rd_q;
	reg [3:0] mc_d;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function is_xram;
		input [15:0] a;
		input en;
		begin
			is_xram = en && (a <= `MSD_XRAM_LAST);
		end
	endfunction

	function [7:0] set_bit;
		input [7:0] v;
		input [2:0] pos;
		input b;
		reg [7:0] r;
		begin
			r = v;
			r[pos] = b;
			set_bit = r;
		end
	endfunction

	wire stretch_en = pwr_mgmt_q[`MSD_XRAM_EN_BIT];
	wire [2:0] stretch = clk_stretch_q[`MSD_STRETCH_MSB:`MSD_STRETCH_LSB];
	wire mc_tick = (phase_q == `MSD_PHASE_LAST);
	wire is_data = req_kind[1];
	wire bit_ok = (sfr_addr[2:0] == 3'h0);
	// Direct addresses below the register space belong to the core's scratchpad
	wire sfr_space = (sfr_addr >= `MSD_SFR_BASE);
	wire xram_sel = (state_q == ST_XRAM) || (req && (state_q == ST_IDLE) && is_data
		&& is_xram(req_addr, stretch_en));
	wire [7:0] xram_rdata;

	msd_xram #(
		.AW(XRAM_AW)
	) u_xram (
		.clock(clock),
		.ce(ce),
		.en(xram_sel && (state_q == ST_IDLE)),
		.we(req_kind == K_DWR),
		.addr(req_addr[XRAM_AW-1:0]),
		.wdata(req_wdata),
		.rdata(xram_rdata)
	);

	// ----------------------------------------------------------------
	// Register file, direct addressing only
	// ----------------------------------------------------------------
	always @(posedge clock)
	begin
		if (rst)
		begin
			clk_stretch_q <= `MSD_CLK_STRETCH_RST;
			pwr_mgmt_q <= `MSD_PWR_MGMT_RST;
			sfr_rdata <= `MSD_UNIMPL_READ;
			sfr_hit <= 1'b0;
			sfr_bit_err <= 1'b0;
		end
		else if (ce)
		begin
			sfr_bit_err <= (sfr_rd || sfr_wr) && sfr_bit && !bit_ok;
			sfr_hit <= 1'b0;
			if (sfr_wr && sfr_space && (!sfr_bit || bit_ok))
			begin
				if (sfr_addr == `MSD_SFR_CLK_STRETCH)
					clk_stretch_q <= sfr_bit ?
						set_bit(clk_stretch_q, sfr_bitsel, sfr_wdata[0]) : sfr_wdata;
				if (sfr_addr == `MSD_SFR_PWR_MGMT)
					pwr_mgmt_q <= sfr_bit ?
						set_bit(pwr_mgmt_q, sfr_bitsel, sfr_wdata[0]) : sfr_wdata;
			end
			if (sfr_rd)
			begin
				// Unused power management bits are stored but are ORed high on read
				if (sfr_addr == `MSD_SFR_CLK_STRETCH)
				begin
					sfr_rdata <= clk_stretch_q;
					sfr_hit <= 1'b1;
				end
				else if (sfr_addr == `MSD_SFR_PWR_MGMT)
				begin
					sfr_rdata <= pwr_mgmt_q | `MSD_PWR_MGMT_UNUSED;
					sfr_hit <= 1'b1;
				end
				else
					sfr_rdata <= `MSD_UNIMPL_READ;
			end
		end
	end

	// ----------------------------------------------------------------
	// Access sequencer, counted in machine cycles of four phases
	// ----------------------------------------------------------------
	always @*
	begin
		mc_d = mc_q;
		if (mc_tick)
			mc_d = mc_q + 4'h1;
	end

	always @(posedge clock)
	begin
		if (rst)
		begin
			state_q <= ST_IDLE;
			phase_q <= 2'h0;
			mc_q <= 4'h0;
			mc_end_q <= 4'h0;
			kind_q <= K_FETCH;
			addr_q <= 16'h0000;
			wdata_q <= 8'h00;
			xram_rd_q <= 1'b0;
			done <= 1'b0;
			rdata <= 8'h00;
			from_flash <= 1'b0;
			p0_out <= 8'h00;
			p0_oe <= 8'h00;
			p2_out <= 8'h00;
			p2_strong <= 1'b0;
			addr_latch_en <= 1'b0;
			prog_rd_n <= 1'b1;
			data_rd_n <= 1'b1;
			data_wr_n <= 1'b1;
			onchip_xram_enable <= 1'b0;
		end
		else if (ce)
		begin
			done <= 1'b0;
			onchip_xram_enable <= stretch_en;
			phase_q <= phase_q + 2'h1;
			mc_q <= mc_d;
			xram_rd_q <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					// Idle port 0 is open drain: drive only the zeros of the latch
					p0_out <= 8'h00;
					p0_oe <= ~p0_latch;
					p2_out <= p2_latch;
					p2_strong <= 1'b0;
					phase_q <= 2'h0;
					mc_q <= 4'h0;
					if (req)
					begin
						kind_q <= req_kind;
						addr_q <= req_addr;
						wdata_q <= req_wdata;
						if (is_data && is_xram(req_addr, stretch_en))
						begin
							state_q <= ST_XRAM;
							mc_end_q <= `MSD_XRAM_MC;
							xram_rd_q <= (req_kind == K_DRD);
						end
						else if (!is_data && ext_access_pin && (req_addr < `MSD_FLASH_TOP))
						begin
							state_q <= ST_FLASH;
							mc_end_q <= `MSD_FLASH_MC;
						end
						else
						begin
							state_q <= ST_ADDR;
							// Machine count already reads 1 when the strobe phase starts
							mc_end_q <= is_data ? `MSD_EXTERNAL_DATA_MOVE_BASE_MC + {1'b0, stretch} :
								`MSD_FETCH_EXT_MC;
						end
					end
				end
				ST_FLASH:
				begin
					// Flash array lives in the core; only routing is reported
					if (mc_tick)
					begin
						from_flash <= 1'b1;
						done <= 1'b1;
						rdata <= 8'h00;
						state_q <= ST_IDLE;
					end
				end
				ST_XRAM:
				begin
					if (xram_rd_q)
						rdata <= xram_rdata;
					if (mc_tick && (mc_d == mc_end_q))
					begin
						done <= 1'b1;
						from_flash <= 1'b0;
						state_q <= ST_IDLE;
					end
				end
				ST_ADDR:
				begin
					// Address phase: both ports strong
					p0_out <= addr_q[7:0];
					p0_oe <= 8'hff;
					p2_out <= addr_q[15:8];
					p2_strong <= 1'b1;
					addr_latch_en <= (phase_q != `MSD_PHASE_LAST);
					if (mc_tick)
					begin
						state_q <= ST_STROBE;
						if (kind_q != K_DWR)
							p0_oe <= 8'h00;
					end
				end
				ST_STROBE:
				begin
					addr_latch_en <= 1'b0;
					// Strobe spans the stretched middle of the access
					prog_rd_n <= kind_q[1];
					data_rd_n <= (kind_q != K_DRD);
					data_wr_n <= (kind_q != K_DWR);
					if (kind_q == K_DWR)
						p0_out <= wdata_q;
					if (mc_tick && (mc_d == mc_end_q))
					begin
						rdata <= p0_in;
						state_q <= ST_END;
					end
				end
				ST_END:
				begin
					prog_rd_n <= 1'b1;
					data_rd_n <= 1'b1;
					data_wr_n <= 1'b1;
					p0_oe <= 8'h00;
					p2_strong <= 1'b0;
					from_flash <= 1'b0;
					done <= 1'b1;
					state_q <= ST_IDLE;
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end
endmodule

//--- tb/msd_asserts.sv
/*
 * Concurrent checks on the memory space decoder ports.
 * Assumes it is bound into msd_decoder with ce held high.
 */
module msd_asserts (
	input wire clock, // System clock
	input wire rst, // Synchronous reset
	input wire req, // Core request
	input wire [1:0] req_kind, // Request kind
	input wire [15:0] req_addr, // Request address
	input wire ext_access_pin, // External-access pin
	input wire sfr_rd, // Register read strobe
	input wire sfr_wr, // Register write strobe
	input wire sfr_bit, // Bit access
	input wire [7:0] sfr_addr, // Register address
	input wire done, // Request finished
	input wire from_flash, // Flash route
	input wire [7:0] sfr_rdata, // Register read data
	input wire sfr_hit, // Block register hit
	input wire sfr_bit_err, // Bit access refused
	input wire [7:0] p0_oe, // Port 0 enables
	input wire p2_strong, // Port 2 strong drive
	input wire addr_latch_en, // Address strobe
	input wire prog_rd_n, // Program read strobe
	input wire data_rd_n, // Data read strobe
	input wire data_wr_n, // Data write strobe
	input wire onchip_xram_enable // SRAM enable
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_rst_clears: assert property (disable iff (1'b0) rst |=> !onchip_xram_enable &&
		data_rd_n && data_wr_n && prog_rd_n) else $error("reset state wrong");
	a_sram_quiet: assert property (req && req_kind[1] && onchip_xram_enable &&
		req_addr[15:10] == 6'h00 |-> data_rd_n && data_wr_n && !addr_latch_en)
		else $error("bus cycle for on-chip access");
	a_sram_time: assert property ($rose(req) && req_kind[1] && onchip_xram_enable &&
		req_addr[15:10] == 6'h00 |-> ##9 done) else $error("on-chip move length");
	a_flash_quiet: assert property (req && req_kind == 2'h0 && ext_access_pin &&
		!req_addr[15] |-> prog_rd_n) else $error("strobe on flash fetch");
	a_ext_fetch: assert property ($rose(req) && req_kind == 2'h0 &&
		req_addr[15] |-> ##6 !prog_rd_n) else $error("no external fetch");
	a_p0_drives: assert property (!data_wr_n |-> p0_oe == 8'hff)
		else $error("port 0 not driven");
	a_p2_strong: assert property (!data_rd_n || !data_wr_n |-> p2_strong)
		else $error("port 2 weak");
	a_strobe_len: assert property ($fell(data_rd_n) |-> !data_rd_n [*4])
		else $error("read strobe short");
	a_bit_check: assert property ((sfr_rd || sfr_wr) && sfr_bit |=>
		sfr_bit_err == (($past(sfr_addr) & 8'h07) != 8'h00)) else $error("bit refusal");
	a_unimpl_ones: assert property (sfr_rd && sfr_addr == 8'h85 |=>
		sfr_rdata == 8'hff && !sfr_hit) else $error("empty location read");

	c_sram_on: cover property ($rose(onchip_xram_enable));
	c_ext_write: cover property ($fell(data_wr_n));
	c_flash_done: cover property (done && from_flash);
endmodule

bind msd_decoder msd_asserts u_msd_asserts (.*);

//--- tb/msd_ext_mem.sv
/*
 * External program and data memory on the multiplexed port 0/2 bus.
 * Assumes the address is latched while addr_latch_en is high.
 */
module msd_ext_mem (
	input wire logic clock, // System clock
	input wire logic addr_latch_en, // Address strobe
	input wire logic [7:0] p0_out, // Port 0 from device
	input wire logic [7:0] p2_out, // Port 2 from device
	input wire logic prog_rd_n, // Program read strobe
	input wire logic data_rd_n, // Data read strobe
	input wire logic data_wr_n, // Data write strobe
	output logic [7:0] p0_in // Port 0 to device
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:65535];
	logic [15:0] addr_q;
	logic [7:0] last_q = 8'h00;
	initial
	begin
		for (int i = 0; i < 65536; i++)
			mem[i] = i[7:0] ^ i[15:8];
	end
	always @(posedge clock)
	begin
		if (addr_latch_en)
			addr_q <= {p2_out, p0_out};
		if (!data_wr_n)
			mem[addr_q] <= p0_out;
		last_q <= p0_in;
	end
	// Released bus toggles so a stale byte never reads as good
	assign p0_in = (!data_rd_n || !prog_rd_n) ? mem[addr_q] : ~last_q;
endmodule

//--- tb/msd_decoder_tb.sv
/*
 * Self-checking bench for the memory space decoder.
 * Assumes the external memory model fills each byte with addr_lo ^ addr_hi.
 */
module msd_decoder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 0, rst = 1, ce = 1, ext_access_pin = 1, req = 0;
	logic sfr_rd = 0, sfr_wr = 0, sfr_bit = 0;
	logic [1:0] req_kind = 0;
	logic [15:0] req_addr = 0;
	logic [7:0] req_wdata = 0, sfr_addr = 0, sfr_wdata = 0, p0_in;
	logic [7:0] p0_latch = 8'hff, p2_latch = 8'hff;
	logic [2:0] sfr_bitsel = 0;
	logic done, from_flash, sfr_hit, sfr_bit_err, p2_strong, addr_latch_en;
	logic prog_rd_n, data_rd_n, data_wr_n, onchip_xram_enable;
	logic [7:0] rdata, sfr_rdata, p0_out, p0_oe, p2_out;
	int n_errors = 0, cmp_count = 0;

	msd_decoder u_msd_decoder (.*);
	msd_ext_mem u_msd_ext_mem (.*);

	always #5 clock = ~clock;

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task chk(input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task test_done;
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task special_function_register(input logic w, b, input logic [7:0] a, d);
		@(posedge clock);
		#1 {sfr_wr, sfr_rd, sfr_bit, sfr_addr, sfr_wdata} = {w, !w, b, a, d};
		@(posedge clock);
		#1 {sfr_wr, sfr_rd} = 2'b00;
	endtask

	// Counts edges from take to done; req held the whole time
	task acc(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d, output int n);
		n = 0;
		@(posedge clock);
		#1 {req, req_kind, req_addr, req_wdata} = {1'b1, k, a, d};
		do
		begin
			@(posedge clock);
			#1 n++;
		end while (done !== 1'b1 && n < 200);
		req = 0;
		if (done !== 1'b1)
		begin
			n_errors++;
			$display("wrong value at %0t: no done", $time);
			test_done;
		end
		@(posedge clock);
		#1;
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial
	begin
		int n;
		repeat (8) @(posedge clock);
		#1 rst = 0;
		special_function_register(0, 0, 8'h8e, 8'h00);
		chk(sfr_rdata, 8'h01);
		special_function_register(0, 0, 8'hc4, 8'h00);
		chk(sfr_rdata, 8'hfe);
		special_function_register(0, 0, 8'h85, 8'h00);
		chk({sfr_hit, sfr_rdata}, 9'h0ff);
		chk(onchip_xram_enable, 1'b0);
		$display("reset test done");
		for (int s = 0; s < 8; s++)
		begin
			special_function_register(1, 0, 8'h8e, s[7:0]);
			acc(2'h3, 16'h0010 + s[15:0], 8'h30 + s[7:0], n);
			chk(n, (2 + s) * 4 + 2);
			acc(2'h2, 16'h0010 + s[15:0], 8'h00, n);
			chk(rdata, 8'h30 + s[7:0]);
		end
		$display("stretch test done");
		special_function_register(1, 0, 8'hc4, 8'h01);
		@(posedge clock);
		#1 chk(onchip_xram_enable, 1'b1);
		acc(2'h3, 16'h03ff, 8'ha5, n);
		chk(n, 9);
		special_function_register(1, 0, 8'hff, 8'h00);
		acc(2'h2, 16'h03ff, 8'h00, n);
		chk(rdata, 8'ha5);
		chk(u_msd_ext_mem.mem[16'h03ff], 8'hfc);
		acc(2'h3, 16'h0400, 8'h5c, n);
		chk(u_msd_ext_mem.mem[16'h0400], 8'h5c);
		acc(2'h2, 16'hfe12, 8'h00, n);
		chk(rdata, 8'hec);
		$display("sram test done");
		p0_latch = 8'h5a;
		p2_latch = 8'h3c;
		@(posedge clock);
		#1 chk({p0_out, p0_oe, p2_out, p2_strong}, {8'h00, 8'ha5, 8'h3c, 1'b0});
		acc(2'h0, 16'h7fff, 8'h00, n);
		chk({from_flash, n[15:0]}, {1'b1, 16'd5});
		acc(2'h0, 16'h8000, 8'h00, n);
		chk({from_flash, rdata}, 9'h080);
		chk(n, 10);
		acc(2'h1, 16'h8123, 8'h00, n);
		chk(rdata, 8'ha2);
		ext_access_pin = 0;
		acc(2'h0, 16'h0234, 8'h00, n);
		chk({from_flash, rdata}, 9'h036);
		special_function_register(1, 1, 8'hc4, 8'h00);
		chk(sfr_bit_err, 1'b1);
		special_function_register(0, 0, 8'hc4, 8'h00);
		chk(sfr_rdata, 8'hff);
		special_function_register(1, 1, 8'h88, 8'h00);
		chk(sfr_bit_err, 1'b0);
		$display("fetch and bit test done");
		test_done;
	end
endmodule
